// *** logic/embedded_memory_block.sv ***
// Purpose: configurable embedded memory block: dual-group ram, single port, rom lookup and 32x32 cam
// Assumes: one clock; the two register groups are told apart by their clock enables and clears
// Notes: group a = write side (read/write mode) or input side (input/output mode); group b = read/output side
//
// Behaviour
// - write data, write strobe, write address registers run on group a only.
// - read strobe and read address registers run on group b in read/write mode only; output data registers run on group b.
// - read and write groups have independent enables and asynchronous clears.
// - input/output mode: all input registers share group a.
// - input/output mode: output registers on group b, separate enable and clear.
// - every register clears asynchronously from group clear or global reset.
// - single-port mode shares one address for reads and writes.
// - cam compares a search word against all entries in parallel, returns address.
// - match flag high whenever any entry matches.
// - cam holds 32 entries of 32 bits.
// - don't-care bits of an entry are ignored in comparison.
// - encoded output gives binary address of the matching entry.
// - unencoded output gives the hit vector, one bit per entry, over two cycles on 16 lines.
// - cam loads initial contents at configuration and is writable in operation.
// - cam write takes two cycles, three with don't-care bits.
// - each input register and read data register can be bypassed separately.
// - rom mode returns a configured pattern per address, writes ignored.
// - ram shapes 128x16, 256x8, 512x4, 1024x2, 2048x1 of 2048 bits.
`timescale 1ns/1ps
`include "embedded_memory_block_regs.svh"

module embedded_memory_block #(
    parameter logic [`EMB_RAM_BITS-1:0] RAM_INIT = '0,
    parameter logic [`EMB_CAM_ARRAY-1:0] CAM_INIT = '0,
    parameter logic [`EMB_CAM_ARRAY-1:0] CAM_CARE_INIT = '1
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // configuration
    input wire embedded_memory_block_pkg::mode_e mode,
    input wire embedded_memory_block_pkg::width_e width_sel,
    input wire logic [`EMB_BYP_W-1:0] in_bypass,
    input wire logic rdata_bypass,
    input wire logic unencoded_sel,
    // register group enables and clears
    input wire logic ce_a,
    input wire logic ce_b,
    input wire logic clr_a_n,
    input wire logic clr_b_n,
    // write side
    input wire logic [`EMB_CAM_BITS-1:0] wdata,
    input wire logic [`EMB_ADDR_W-1:0] waddr,
    input wire logic write_strobe,
    input wire logic [`EMB_CAM_BITS-1:0] cam_dontcare,
    input wire logic cam_mask_write,
    // read side
    input wire logic read_strobe,
    input wire logic [`EMB_ADDR_W-1:0] raddr,
    // outputs
    output logic [`EMB_RDATA_W-1:0] rdata,
    output logic cam_match,
    output logic [`EMB_CAM_AW-1:0] cam_addr,
    output logic [`EMB_CAM_HALF-1:0] cam_vec,
    output logic cam_vec_valid,
    output logic cam_vec_upper
);
    import embedded_memory_block_pkg::*;

    // ----------------------------------------
    // group routing and clears
    // ----------------------------------------
    logic rd_in_en;
    logic clr_a_all_n;
    logic clr_b_all_n;
    logic clr_rd_in_n;
    logic is_rw;

    assign is_rw = (mode == MODE_RW_CLOCK);
    assign clr_a_all_n = reset_n & clr_a_n;
    assign clr_b_all_n = reset_n & clr_b_n;
    // read strobe and read address follow the read group only in read/write mode
    assign rd_in_en = is_rw ? ce_b : ce_a;
    assign clr_rd_in_n = is_rw ? clr_b_all_n : clr_a_all_n;

    // ----------------------------------------
    // input register stages
    // ----------------------------------------
    logic [`EMB_CAM_BITS-1:0] wdata_q;
    logic [`EMB_ADDR_W-1:0] waddr_q;
    logic we_q;
    logic re_q;
    logic [`EMB_ADDR_W-1:0] raddr_q;

    reg_stage #(.W(`EMB_CAM_BITS), .CAN_BYPASS(1'b1)) u_wdata (
        .clock(clock),
        .clear_n(clr_a_all_n),
        .clk_en(clk_en),
        .grp_en(ce_a),
        .bypass(in_bypass[`EMB_BYP_WDATA]),
        .d(wdata),
        .q(wdata_q)
    );
    reg_stage #(.W(`EMB_ADDR_W), .CAN_BYPASS(1'b1)) u_waddr (
        .clock(clock),
        .clear_n(clr_a_all_n),
        .clk_en(clk_en),
        .grp_en(ce_a),
        .bypass(in_bypass[`EMB_BYP_WADDR]),
        .d(waddr),
        .q(waddr_q)
    );
    reg_stage #(.W(1), .CAN_BYPASS(1'b1)) u_we (
        .clock(clock),
        .clear_n(clr_a_all_n),
        .clk_en(clk_en),
        .grp_en(ce_a),
        .bypass(in_bypass[`EMB_BYP_WE]),
        .d(write_strobe),
        .q(we_q)
    );
    reg_stage #(.W(1), .CAN_BYPASS(1'b1)) u_re (
        .clock(clock),
        .clear_n(clr_rd_in_n),
        .clk_en(clk_en),
        .grp_en(rd_in_en),
        .bypass(in_bypass[`EMB_BYP_RE]),
        .d(read_strobe),
        .q(re_q)
    );
    reg_stage #(.W(`EMB_ADDR_W), .CAN_BYPASS(1'b1)) u_raddr (
        .clock(clock),
        .clear_n(clr_rd_in_n),
        .clk_en(clk_en),
        .grp_en(rd_in_en),
        .bypass(in_bypass[`EMB_BYP_RADDR]),
        .d(raddr),
        .q(raddr_q)
    );

    // ----------------------------------------
    // core state
    // ----------------------------------------
    core_s st_reg;
    core_s st_next;

    // configuration contents, restored by every clear of the write group
    localparam core_s ST_INIT = '{
        mem: RAM_INIT,
        cam_data: CAM_INIT,
        cam_care: CAM_CARE_INIT,
        cam_state: CAM_IDLE,
        cw_addr: '0,
        cw_data: '0,
        cw_mask: 1'b0,
        hi_pending: 1'b0,
        hi_half: '0
    };

    // ----------------------------------------
    // ram addressing
    // ----------------------------------------
    logic [`EMB_ADDR_W-1:0] wr_base;
    logic [`EMB_ADDR_W-1:0] rd_base;
    logic [`EMB_ADDR_W-1:0] rd_addr_sel;
    logic [`EMB_ADDR_W-1:0] addr_mask;
    logic [`EMB_RDATA_W-1:0] lane_en;
    logic [`EMB_RDATA_W-1:0] ram_rd;
    logic ram_write;
    logic ram_read;

    assign addr_mask = `EMB_ADDR_ALL >> width_sel;
    // a single port reads at the write address and only while not writing
    assign rd_addr_sel = (mode == MODE_SINGLE_PORT) ? waddr_q : raddr_q;
    assign wr_base = (waddr_q & addr_mask) << width_sel;
    assign rd_base = (rd_addr_sel & addr_mask) << width_sel;
    assign ram_write = we_q && ce_a && (mode == MODE_RW_CLOCK || mode == MODE_IO_CLOCK
        || mode == MODE_SINGLE_PORT);
    assign ram_read = re_q && !(mode == MODE_SINGLE_PORT && we_q);

    always_comb begin
        lane_en = '0;
        ram_rd = '0;
        for (int i = 0; i < `EMB_RDATA_W; i++) begin
            lane_en[i] = (i < (1 << width_sel));
            if (lane_en[i]) begin
                // reads the stored state, so a same-cycle write is not yet visible
                ram_rd[i] = st_reg.mem[rd_base + `EMB_ADDR_W'(i)];
            end
        end
    end

    // ----------------------------------------
    // cam search
    // ----------------------------------------
    logic [`EMB_CAM_WORDS-1:0] hit;
    logic [`EMB_CAM_AW-1:0] hit_addr;
    logic any_hit;
    logic search;

    assign search = (mode == MODE_CAM) && re_q;

    always_comb begin
        hit = '0;
        hit_addr = '0;
        for (int e = 0; e < `EMB_CAM_WORDS; e++) begin
            // masked compare on every entry at once
            hit[e] = ((st_reg.cam_data[e*`EMB_CAM_BITS +: `EMB_CAM_BITS] ^ wdata_q)
                & st_reg.cam_care[e*`EMB_CAM_BITS +: `EMB_CAM_BITS]) == '0;
        end
        // highest entry wins, so duplicates give one of the matching addresses only
        for (int e = 0; e < `EMB_CAM_WORDS; e++) begin
            if (hit[e]) begin
                hit_addr = `EMB_CAM_AW'(e);
            end
        end
    end
    assign any_hit = |hit;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic [`EMB_CAM_AW+`EMB_CAM_HALF+3-1:0] cam_out_d;

    always_comb begin
        st_next = st_reg;
        cam_out_d = {1'b0, `EMB_CAM_AW'(0), `EMB_ZERO16, 1'b0, 1'b0};
        if (clk_en) begin
            if (ram_write) begin
                for (int i = 0; i < `EMB_RDATA_W; i++) begin
                    if (lane_en[i]) begin
                        st_next.mem[wr_base + `EMB_ADDR_W'(i)] = wdata_q[i];
                    end
                end
            end
            if (ce_a) begin
                case (st_reg.cam_state)
                    CAM_IDLE: begin
                        if (mode == MODE_CAM && we_q) begin
                            st_next.cw_addr = waddr_q[`EMB_CAM_AW-1:0];
                            st_next.cw_data = wdata_q;
                            st_next.cw_mask = cam_mask_write;
                            st_next.cam_state = CAM_WRITE_DATA;
                        end
                    end
                    CAM_WRITE_DATA: begin
                        st_next.cam_data[st_reg.cw_addr*`EMB_CAM_BITS +: `EMB_CAM_BITS] = st_reg.cw_data;
                        st_next.cam_care[st_reg.cw_addr*`EMB_CAM_BITS +: `EMB_CAM_BITS] = `EMB_CARE_ALL;
                        st_next.cam_state = st_reg.cw_mask ? CAM_WRITE_MASK : CAM_IDLE;
                    end
                    CAM_WRITE_MASK: begin
                        st_next.cam_care[st_reg.cw_addr*`EMB_CAM_BITS +: `EMB_CAM_BITS] = ~cam_dontcare;
                        st_next.cam_state = CAM_IDLE;
                    end
                    default: begin
                        st_next.cam_state = CAM_IDLE;
                    end
                endcase
            end
        end
        // output image: match, address, vector, valid, upper-half flag
        if (search) begin
            cam_out_d = {any_hit, hit_addr, unencoded_sel ? hit[`EMB_CAM_HALF-1:0] : `EMB_ZERO16,
                unencoded_sel, 1'b0};
        // the upper half only follows a lower half still standing, so a read-side clear drops it
        end else if (st_reg.hi_pending && cam_vec_valid && !cam_vec_upper) begin
            cam_out_d = {cam_match, cam_addr, st_reg.hi_half, 1'b1, 1'b1};
        end
        if (clk_en && ce_b) begin
            st_next.hi_pending = search && unencoded_sel;
            st_next.hi_half = hit[`EMB_CAM_WORDS-1:`EMB_CAM_HALF];
        end
    end

    always_ff @(posedge clock or negedge clr_a_all_n) begin
        if (!clr_a_all_n) begin
            st_reg <= ST_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // output register stages (read group)
    // ----------------------------------------
    logic [`EMB_RDATA_W-1:0] rd_q;

    reg_stage #(.W(`EMB_RDATA_W), .CAN_BYPASS(1'b1)) u_rd (
        .clock(clock),
        .clear_n(clr_b_all_n),
        .clk_en(clk_en),
        .grp_en(ce_b && ram_read),
        .bypass(rdata_bypass),
        .d(ram_rd),
        .q(rd_q)
    );
    reg_stage #(.W(`EMB_RDATA_W), .CAN_BYPASS(1'b0)) u_dout (
        .clock(clock),
        .clear_n(clr_b_all_n),
        .clk_en(clk_en),
        .grp_en(ce_b),
        .bypass(1'b0),
        .d(rd_q),
        .q(rdata)
    );
    reg_stage #(.W(`EMB_CAM_AW+`EMB_CAM_HALF+3), .CAN_BYPASS(1'b0)) u_cam_out (
        .clock(clock),
        .clear_n(clr_b_all_n),
        .clk_en(clk_en),
        .grp_en(ce_b),
        .bypass(1'b0),
        .d(cam_out_d),
        .q({cam_match, cam_addr, cam_vec, cam_vec_valid, cam_vec_upper})
    );

endmodule : embedded_memory_block

// *** logic/embedded_memory_block_pkg.sv ***
// Purpose: types shared by the embedded memory block modules
// Assumes: geometry macros from the regs header
// Notes: mode, width and cam state encodings and the core state struct
`include "embedded_memory_block_regs.svh"

package embedded_memory_block_pkg;

    // ----------------------------------------
    // configuration types
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_RW_CLOCK,
        MODE_IO_CLOCK,
        MODE_SINGLE_PORT,
        MODE_ROM,
        MODE_CAM
    } mode_e;

    // value is log2 of the data width: 2048x1 up to 128x16
    typedef enum logic [`EMB_LG_W-1:0] {
        WIDTH_X1,
        WIDTH_X2,
        WIDTH_X4,
        WIDTH_X8,
        WIDTH_X16
    } width_e;

    typedef enum {
        CAM_IDLE,
        CAM_WRITE_DATA,
        CAM_WRITE_MASK
    } cam_state_e;

    // ----------------------------------------
    // core state of the block
    // ----------------------------------------
    typedef struct packed {
        logic [`EMB_RAM_BITS-1:0] mem;
        logic [`EMB_CAM_ARRAY-1:0] cam_data;
        logic [`EMB_CAM_ARRAY-1:0] cam_care;
        cam_state_e cam_state;
        logic [`EMB_CAM_AW-1:0] cw_addr;
        logic [`EMB_CAM_BITS-1:0] cw_data;
        logic cw_mask;
        logic hi_pending;
        logic [`EMB_CAM_HALF-1:0] hi_half;
    } core_s;

endpackage : embedded_memory_block_pkg

// *** logic/embedded_memory_block_regs.svh ***
// Purpose: sizes, field widths and reset values of the embedded memory block
// Assumes: included by the package and the block module by bare name
// Notes: definitions only
`ifndef EMBEDDED_MEMORY_BLOCK_REGS_SVH
`define EMBEDDED_MEMORY_BLOCK_REGS_SVH

// ----------------------------------------
// ram geometry
// ----------------------------------------
`define EMB_RAM_BITS 2048
`define EMB_ADDR_W 11
`define EMB_RDATA_W 16
`define EMB_LG_W 3
`define EMB_ADDR_ALL 11'h7ff

// ----------------------------------------
// cam geometry
// ----------------------------------------
`define EMB_CAM_WORDS 32
`define EMB_CAM_BITS 32
`define EMB_CAM_AW 5
`define EMB_CAM_HALF 16
`define EMB_CAM_ARRAY 1024

// ----------------------------------------
// input register bypass select bits
// ----------------------------------------
`define EMB_BYP_WDATA 0
`define EMB_BYP_WADDR 1
`define EMB_BYP_WE 2
`define EMB_BYP_RE 3
`define EMB_BYP_RADDR 4
`define EMB_BYP_W 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define EMB_CARE_ALL 32'hffffffff
`define EMB_ZERO16 16'h0000

`endif

// *** logic/reg_stage.sv ***
// Purpose: one clearable, enabled, optionally bypassed register stage
// Assumes: clear_n is already the combination of all clears for its group
// Notes: with CAN_BYPASS at 0 the output is the flip-flop itself
`timescale 1ns/1ps

module reg_stage #(
    parameter int W = 1,
    parameter bit CAN_BYPASS = 1'b1
) (
    // clock and clears
    input wire logic clock,
    input wire logic clear_n,
    input wire logic clk_en,
    input wire logic grp_en,
    // control
    input wire logic bypass,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] val;
    } stage_s;

    stage_s st_reg;
    stage_s st_next;

    always_comb begin
        st_next = st_reg;
        if (clk_en && grp_en) begin
            st_next.val = d;
        end
    end

    always_ff @(posedge clock or negedge clear_n) begin
        if (!clear_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = (CAN_BYPASS && bypass) ? d : st_reg.val;

endmodule : reg_stage

// *** verif/cam_result_reader.sv ***
// Purpose: neighbouring logic that assembles the two-cycle hit vector
// Assumes: lower half always precedes upper half
// Notes: a lone upper half is dropped onto a stale lower half
`timescale 1ns/1ps

module cam_result_reader (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // hit lines
    input wire logic [15:0] cam_vec,
    input wire logic cam_vec_valid,
    input wire logic cam_vec_upper,
    // assembled vector
    output logic [31:0] hits
);
    logic [15:0] lo_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lo_reg <= 16'h0000;
            hits <= 32'h0000_0000;
        end else if (cam_vec_valid && !cam_vec_upper) begin
            lo_reg <= cam_vec;
        end else if (cam_vec_valid) begin
            hits <= {cam_vec, lo_reg};
        end
    end
endmodule : cam_result_reader

// *** verif/embedded_memory_block_assertions.sv ***
// Purpose: port-level timing checks of the embedded memory block
// Assumes: one clock; outputs are registered
// Notes: bound into every instance of the block
`timescale 1ns/1ps

module embedded_memory_block_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // controls
    input wire logic clk_en,
    input wire logic ce_a,
    input wire logic ce_b,
    input wire logic clr_a_n,
    input wire logic clr_b_n,
    input wire embedded_memory_block_pkg::mode_e mode,
    input wire logic [4:0] in_bypass,
    input wire logic rdata_bypass,
    input wire logic unencoded_sel,
    input wire logic read_strobe,
    // outputs
    input wire logic [15:0] rdata,
    input wire logic cam_match,
    input wire logic [4:0] cam_addr,
    input wire logic [15:0] cam_vec,
    input wire logic cam_vec_valid,
    input wire logic cam_vec_upper
);
    import embedded_memory_block_pkg::*;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_lower_half_first: assert property (
        read_strobe && mode == MODE_CAM && unencoded_sel && clk_en && ce_a && ce_b && clr_a_n && clr_b_n
        && in_bypass == 5'h00 ##1 clk_en && ce_b && clr_a_n && clr_b_n && mode == MODE_CAM && unencoded_sel
        |=> cam_vec_valid && !cam_vec_upper) else $error("lower half late");
    a_upper_after_lower: assert property (
        cam_vec_valid && cam_vec_upper && $past(clk_en) && $past(ce_b)
        |-> $past(cam_vec_valid) && !$past(cam_vec_upper)) else $error("upper half out of order");
    a_vec_implies_match: assert property (cam_vec_valid && cam_vec != 16'h0000 |-> cam_match)
        else $error("hit lines without match flag");
    a_addr_in_vec: assert property (
        cam_vec_valid && !cam_vec_upper && cam_match && !cam_addr[4]
        |-> cam_vec[cam_addr[3:0]]) else $error("encoded address not a hit");
    a_encoded_quiet: assert property (
        !unencoded_sel && !$past(unencoded_sel) && !$past(unencoded_sel, 2)
        && $past(clk_en) && $past(ce_b) && $past(clk_en, 2) && $past(ce_b, 2)
        |-> !cam_vec_valid) else $error("hit lines in encoded mode");
    a_clear_b_out: assert property (!clr_b_n |-> rdata == 16'h0000 && !cam_match && !cam_vec_valid)
        else $error("read side not cleared");
    a_reset_zero: assert property ($rose(reset_n) |-> rdata == 16'h0000 && !cam_match)
        else $error("outputs not zero after reset");
    a_freeze_rdata: assert property (
        !clk_en && clr_b_n && !rdata_bypass && in_bypass == 5'h00
        |=> !clr_b_n || $stable(rdata)) else $error("read data moved while frozen");
endmodule : embedded_memory_block_assertions

bind embedded_memory_block embedded_memory_block_assertions embedded_memory_block_assertions_i (
    .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .ce_a(ce_a), .ce_b(ce_b), .clr_a_n(clr_a_n),
    .clr_b_n(clr_b_n), .mode(mode), .in_bypass(in_bypass), .rdata_bypass(rdata_bypass),
    .unencoded_sel(unencoded_sel), .read_strobe(read_strobe), .rdata(rdata), .cam_match(cam_match),
    .cam_addr(cam_addr), .cam_vec(cam_vec), .cam_vec_valid(cam_vec_valid), .cam_vec_upper(cam_vec_upper)
);

// *** verif/embedded_memory_block_test.sv ***
// Purpose: self-checking bench of the embedded memory block
// Assumes: inputs change on the falling edge
// Notes: reference ram uses the same bit layout for every width
`timescale 1ns/1ps

module embedded_memory_block_test;
    import embedded_memory_block_pkg::*;
    localparam logic [2047:0] RINIT = {64{32'h5a3c_1e87}};
    logic clock = 1'b0, reset_n = 1'b0, clk_en = 1'b1, ce_a = 1'b1, ce_b = 1'b1, clr_a_n = 1'b1, clr_b_n = 1'b1;
    mode_e mode = MODE_RW_CLOCK;
    width_e width_sel = WIDTH_X16;
    logic [4:0] in_bypass = 5'h00;
    logic rdata_bypass = 1'b0, unencoded_sel = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0, cam_mask_write = 1'b0;
    logic [31:0] wdata = 32'h0, cam_dontcare = 32'h0, hits, k;
    logic [10:0] waddr = 11'h0, raddr = 11'h0, a;
    logic [15:0] rdata, cam_vec;
    logic cam_match, cam_vec_valid, cam_vec_upper, we;
    logic [4:0] cam_addr, e;
    logic [2047:0] rm = RINIT;
    logic [31:0] cd [32] = '{default: 32'h0};
    logic [31:0] cc [32] = '{default: 32'hffff_ffff};
    int err_count = 0, check_count = 0, seed = 8066, cyc = 0;

    always #2.5 clock = ~clock;

    embedded_memory_block #(.RAM_INIT(RINIT)) embedded_memory_block_i (
        .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .mode(mode), .width_sel(width_sel),
        .in_bypass(in_bypass), .rdata_bypass(rdata_bypass), .unencoded_sel(unencoded_sel), .ce_a(ce_a),
        .ce_b(ce_b), .clr_a_n(clr_a_n), .clr_b_n(clr_b_n), .wdata(wdata), .waddr(waddr),
        .write_strobe(write_strobe), .cam_dontcare(cam_dontcare), .cam_mask_write(cam_mask_write),
        .read_strobe(read_strobe), .raddr(raddr), .rdata(rdata), .cam_match(cam_match), .cam_addr(cam_addr),
        .cam_vec(cam_vec), .cam_vec_valid(cam_vec_valid), .cam_vec_upper(cam_vec_upper)
    );

    cam_result_reader cam_result_reader_i (
        .clock(clock), .reset_n(reset_n), .cam_vec(cam_vec), .cam_vec_valid(cam_vec_valid),
        .cam_vec_upper(cam_vec_upper), .hits(hits)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    // one ram cycle; a same-address read and write return the old word
    task automatic acc(input logic [10:0] ad, input logic [15:0] d, input logic w, input logic r);
        logic [15:0] ex;
        ex = 16'h0000;
        for (int b = 0; b < (1 << width_sel); b++) ex[b] = rm[(ad << width_sel) + b];
        write_strobe = w;
        read_strobe = r;
        waddr = ad;
        raddr = (mode == MODE_SINGLE_PORT) ? ~ad : ad;
        wdata = {16'h0000, d};
        tick(1);
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        for (int b = 0; b < (1 << width_sel); b++) if (w && mode != MODE_ROM) rm[(ad << width_sel) + b] = d[b];
        tick(r ? 2 - int'(rdata_bypass) - int'(in_bypass[4]) : 1);
        if (r) chk(rdata, ex);
    endtask : acc

    // writer holds word and entry for the whole write
    task automatic cw(input logic [4:0] en, input logic [31:0] d, input logic [31:0] dc);
        waddr = {6'h00, en};
        wdata = d;
        cam_dontcare = dc;
        cam_mask_write = |dc;
        write_strobe = 1'b1;
        tick(1);
        write_strobe = 1'b0;
        tick(|dc ? 3 : 2);
        cd[en] = d;
        cc[en] = ~dc;
    endtask : cw

    task automatic cs(input logic [31:0] key);
        logic [31:0] h;
        int top;
        h = 32'h0;
        top = 0;
        for (int i = 0; i < 32; i++) if (((key ^ cd[i]) & cc[i]) == 32'h0) begin
            h[i] = 1'b1;
            top = i;
        end
        wdata = key;
        read_strobe = 1'b1;
        tick(1);
        read_strobe = 1'b0;
        tick(1);
        chk(cam_match, |h);
        if (|h) chk(cam_addr, top[4:0]);
        tick(2);
        if (unencoded_sel) chk(hits, h);
    endtask : cs

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        tick(8);
        reset_n = 1'b1;
        // ----------------------------------------
        // ram modes, widths and register bypasses
        // ----------------------------------------
        for (int m = 0; m < 5; m++) begin
            mode = (m == 1) ? MODE_IO_CLOCK : (m == 2) ? MODE_SINGLE_PORT : MODE_RW_CLOCK;
            rdata_bypass = (m == 3);
            in_bypass = (m == 4) ? 5'h18 : 5'h00;
            for (int w = 0; w < 5; w++) begin
                width_sel = width_e'(w);
                repeat (6) begin
                    a = 11'($random(seed)) & (11'h7ff >> w);
                    we = 1'($random(seed));
                    acc(a, 16'($random(seed)), we, mode != MODE_SINGLE_PORT || !we);
                end
            end
        end
        in_bypass = 5'h00;
        ce_a = 1'b0;
        write_strobe = 1'b1;
        waddr = 11'h003;
        wdata = 32'h0000_c3a5;
        tick(2);
        ce_a = 1'b1;
        acc(11'h003, 16'h0000, 1'b0, 1'b1);
        ce_b = 1'b0;
        acc(11'h003, 16'($random(seed)), 1'b1, 1'b0);
        k = {16'h0000, rdata};
        read_strobe = 1'b1;
        raddr = 11'h003;
        tick(3);
        chk(rdata, k);
        ce_b = 1'b1;
        acc(11'h003, 16'h0000, 1'b0, 1'b1);
        clk_en = 1'b0;
        tick(3);
        clk_en = 1'b1;
        clr_b_n = 1'b0;
        tick(1);
        chk(rdata, 32'h0);
        clr_b_n = 1'b1;
        clr_a_n = 1'b0;
        tick(1);
        clr_a_n = 1'b1;
        rm = RINIT;
        mode = MODE_ROM;
        repeat (4) acc(11'($random(seed)) & 11'h07f, 16'hffff, 1'b1, 1'b1);
        // ----------------------------------------
        // cam: preload, masks, duplicates, random
        // ----------------------------------------
        mode = MODE_CAM;
        tick(2);
        cs(32'h0);
        k = $random(seed);
        cw(5'h0c, k, 32'h0);
        cs(k);
        cw(5'h05, ~k, 32'h0000_00ff);
        cs(~k ^ 32'h0000_005a);
        unencoded_sel = 1'b1;
        tick(3);
        cs(~k);
        cw(5'h14, k, 32'h0);
        cs(k);
        for (int u = 0; u < 2; u++) begin
            unencoded_sel = u[0];
            tick(3);
            repeat (8) begin
                e = 5'($random(seed));
                k = $random(seed);
                cw(e, k, $random(seed) & $random(seed) & {32{k[0]}});
                e = 5'($random(seed));
                cs(cd[e] ^ ($random(seed) & ~cc[e]));
            end
        end
        conclude();
    end
endmodule : embedded_memory_block_test
